/* File: hw/ecs_dout_map.sv */
// Digital output mapper: each output picks one feature by a 3-bit code.
// Assumes the map word is kept by the register file of the sequencer.
module ecs_dout_map
  import ecs_pkg::*;
(
  input  wire logic [23:0]         MAP,
  input  wire logic [7:0]          FEAT,
  output logic [NUM_DOUT-1:0]      DOUT
);
  // An output earlier in the list claims a feature first; later outputs
  // naming the same feature stay off, so one feature drives one output.
  genvar i;
  generate
    for (i = 0; i < NUM_DOUT; i++) begin : g_out
      logic [2:0] sel;
      logic       taken;
      assign sel = MAP[3*i +: 3];
      if (i == 0) begin : g_first
        assign taken = 1'b0;
      end else begin : g_rest
        logic [i-1:0] hit;
        for (genvar j = 0; j < i; j++) begin : g_cmp
          assign hit[j] = (MAP[3*j +: 3] == sel);
        end
        assign taken = |hit; // [RQ21]
      end
      assign DOUT[i] = (sel != FEAT_NONE) && !taken && FEAT[sel];
    end
  endgenerate
endmodule

/* File: hw/ecs_pkg.sv */
// Package: constants, register map and state types of the engine sequencer.
// Assumes a single 50 MHz clock and a plain register port.
package ecs_pkg;
  localparam int unsigned CLK_HZ      = 50000000;
  localparam int unsigned TICK_S      = 1;
  localparam int unsigned TICK_CYC    = CLK_HZ * TICK_S;
  localparam logic [7:0]  BLANK_S     = 8'h02;
  localparam logic [7:0]  FALSE_WIN_S = 8'h0a;
  localparam logic [7:0]  LOCK_S      = 8'h03;
  localparam int unsigned NUM_DOUT    = 8;

  // Register offsets (byte addresses on a 32-bit word port).
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_START_DLY= 8'h04;
  localparam logic [7:0] REG_PREHEAT  = 8'h08;
  localparam logic [7:0] REG_MIDHEAT  = 8'h0c;
  localparam logic [7:0] REG_POSTHEAT = 8'h10;
  localparam logic [7:0] REG_CRANK    = 8'h14;
  localparam logic [7:0] REG_REST     = 8'h18;
  localparam logic [7:0] REG_ATTEMPTS = 8'h1c;
  localparam logic [7:0] REG_WARMUP   = 8'h20;
  localparam logic [7:0] REG_COOL     = 8'h24;
  localparam logic [7:0] REG_E2S      = 8'h28;
  localparam logic [7:0] REG_DISC_SPD = 8'h2c;
  localparam logic [7:0] REG_OIL_THR  = 8'h30;
  localparam logic [7:0] REG_STATUS   = 8'h34;
  localparam logic [7:0] REG_MAP      = 8'h38;

  // Control register bit positions.
  localparam int unsigned CTRL_FUEL_REST = 0;
  localparam int unsigned CTRL_FALSE_EN  = 1;
  localparam int unsigned CTRL_FAIL_CLR  = 2;

  // Output feature selection codes for the digital output map.
  localparam logic [2:0] FEAT_NONE  = 3'h0;
  localparam logic [2:0] FEAT_WARM  = 3'h1;
  localparam logic [2:0] FEAT_E2S   = 3'h2;
  localparam logic [2:0] FEAT_GLOW  = 3'h3;
  localparam logic [2:0] FEAT_COOL  = 3'h4;
  localparam logic [2:0] FEAT_OVCR  = 3'h5;
  localparam logic [2:0] FEAT_CRANK = 3'h6;
  localparam logic [2:0] FEAT_RUN   = 3'h7;

  localparam logic [31:0] MAP_RST = 32'h00000000;

  typedef enum logic [3:0] {
    ST_OFF, ST_DELAY, ST_PREHEAT, ST_CRANK, ST_REST, ST_RUN, ST_COOL, ST_FAIL
  } ecs_state_t;
endpackage

/* File: hw/ecs_seq.sv */
// Engine crank and shutdown sequencer: start, crank, rest, run, cool-down.
// Assumes speed, frequency, oil and keys arrive from pins or other clocks;
// all are synchronised here before use. Timers count in whole seconds.
//
// Notes on behaviour
// [RQ1] Start waits start delay, then glow plug for preheat, fuel on.
// [RQ2] Crank for crank time; on no start drop crank, wait rest.
// [RQ3] Failed crank cuts fuel unless fuel-on-during-rest is set.
// [RQ4] Speed at disconnect releases crank and enters run.
// [RQ5] Display blanked during first 2 s of each crank; not blanked once a locked rotor is seen.
// [RQ6] Nonzero midheat keeps glow on while cranking, off in rest.
// [RQ7] Glow off on crank failure, midheat expiry, success without postheat.
// [RQ8] After rest, fuel and crank return for another attempt.
// [RQ9] Attempts used up gives failure state and over-crank flag.
// [RQ10] False-start restart watches speed 10 s after start.
// [RQ11] Off key inside false-start window goes straight to off.
// [RQ12] Warm-up output off during nonzero warm-up, on after.
// [RQ13] Warm-up output off outside run.
// [RQ14] Nonzero postheat drives glow for postheat on entering run.
// [RQ15] Crank oil threshold zero disables locked rotor detection.
// [RQ16] Low oil with zero speed and frequency cuts crank to 3 s.
// [RQ17] Nothing reached at 3 s stops cranking, locked rotor failure.
// [RQ18] Stop in run with nonzero cool-down enters cool-down output.
// [RQ19] Cool-down expiry drops fuel and enters off.
// [RQ20] Nonzero energize-to-stop time drives its output on stopping.
// [RQ21] Each output feature maps to one digital output at most.
// [RQ22] Over-crank output follows the over-crank failure.
// [RQ23] Glow plug output driven by preheat, midheat and postheat.
// [RQ24] Durations count whole seconds from a tick; reset clears timers.
module ecs_seq
  import ecs_pkg::*;
(
  input  wire logic                MCLK,
  input  wire logic                RST_B,
  input  wire logic                CE,
  input  wire logic [7:0]          ADDR,
  input  wire logic [31:0]         WDATA,
  input  wire logic                WR,
  input  wire logic                RD,
  output logic [31:0]              RDATA,
  input  wire logic [15:0]         SPEED,
  input  wire logic [15:0]         FREQ,
  input  wire logic [15:0]         OIL,
  input  wire logic                START_KEY,
  input  wire logic                STOP_KEY,
  input  wire logic                OFF_KEY,
  output logic                     FUEL,
  output logic                     CRANK,
  output logic                     GLOW,
  output logic                     DISP_BLANK,
  output logic                     OVER_CRANK,
  output logic                     LOCKED_ROTOR,
  output logic [NUM_DOUT-1:0]      DOUT
);
  typedef struct packed {
    // Configuration.
    logic [2:0]  ctrl;
    logic [7:0]  t_dly;
    logic [7:0]  t_pre;
    logic [7:0]  t_mid;
    logic [7:0]  t_post;
    logic [7:0]  t_crank;
    logic [7:0]  t_rest;
    logic [7:0]  attempts;
    logic [7:0]  t_warm;
    logic [7:0]  t_cool;
    logic [7:0]  t_e2s;
    logic [15:0] disc_spd;
    logic [15:0] oil_thr;
    logic [23:0] map;
    // Input synchronisers (stage 1 read only by stage 2).
    logic [50:0] sy1;
    logic [50:0] sy2;
    // Sequencer.
    ecs_state_t  st;
    logic [7:0]  tmr;
    logic [7:0]  mid_tmr;
    logic [7:0]  post_tmr;
    logic [7:0]  warm_tmr;
    logic [7:0]  e2s_tmr;
    logic [7:0]  fs_tmr;
    logic [7:0]  tries;
    logic        fuel;
    logic        glow;
    logic        mid_on;
    logic        locked;
    logic        ovcr;
    logic        lrf;
    logic [31:0] rdata;
  } ecs_seq_st_t;
  ecs_seq_st_t s_q, s_d;

  logic        tick;
  logic [15:0] spd, frq, oil;
  logic        k_start, k_stop, k_off;
  logic        at_speed, lock_cond;
  logic [7:0]  crank_el, lock_left;
  logic [7:0]  feat;

  ecs_tick u_tick (
    .MCLK (MCLK),
    .RST_B(RST_B),
    .CE   (CE),
    .TICK (tick)
  );

  assign spd     = s_q.sy2[15:0];
  assign frq     = s_q.sy2[31:16];
  assign oil     = s_q.sy2[47:32];
  assign k_start = s_q.sy2[48];
  assign k_stop  = s_q.sy2[49];
  assign k_off   = s_q.sy2[50];

  assign at_speed  = (spd >= s_q.disc_spd);
  // A zero threshold never matches, which switches the check off.
  assign lock_cond = (s_q.oil_thr != 16'h0000) && (oil < s_q.oil_thr) &&
                     (spd == 16'h0000) && (frq == 16'h0000); // [RQ15] [RQ16]
  // Time already spent cranking counts toward the 3 s; a shorter crank
  // time still left is kept, so the check never lengthens a crank.
  assign crank_el  = s_q.t_crank - s_q.tmr;
  assign lock_left = (crank_el >= LOCK_S) ? 8'h00 : LOCK_S - crank_el;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.sy1 = {OFF_KEY, STOP_KEY, START_KEY, OIL, FREQ, SPEED};
    s_d.sy2 = s_q.sy1;

    // Register writes.
    if (WR) begin
      unique case (ADDR)
        REG_CTRL:      s_d.ctrl     = WDATA[2:0];
        REG_START_DLY: s_d.t_dly    = WDATA[7:0];
        REG_PREHEAT:   s_d.t_pre    = WDATA[7:0];
        REG_MIDHEAT:   s_d.t_mid    = WDATA[7:0];
        REG_POSTHEAT:  s_d.t_post   = WDATA[7:0];
        REG_CRANK:     s_d.t_crank  = WDATA[7:0];
        REG_REST:      s_d.t_rest   = WDATA[7:0];
        REG_ATTEMPTS:  s_d.attempts = WDATA[7:0];
        REG_WARMUP:    s_d.t_warm   = WDATA[7:0];
        REG_COOL:      s_d.t_cool   = WDATA[7:0];
        REG_E2S:       s_d.t_e2s    = WDATA[7:0];
        REG_DISC_SPD:  s_d.disc_spd = WDATA[15:0];
        REG_OIL_THR:   s_d.oil_thr  = WDATA[15:0];
        REG_MAP:       s_d.map      = WDATA[23:0];
        default:       ;
      endcase
    end
    s_d.ctrl[CTRL_FAIL_CLR] = WR && (ADDR == REG_CTRL) &&
                              WDATA[CTRL_FAIL_CLR];

    // Register reads: data stand one cycle after the strobe.
    s_d.rdata = 32'h0;
    if (RD) begin
      unique case (ADDR)
        REG_CTRL:      s_d.rdata = {30'h0, s_q.ctrl[1:0]};
        REG_START_DLY: s_d.rdata = {24'h0, s_q.t_dly};
        REG_PREHEAT:   s_d.rdata = {24'h0, s_q.t_pre};
        REG_MIDHEAT:   s_d.rdata = {24'h0, s_q.t_mid};
        REG_POSTHEAT:  s_d.rdata = {24'h0, s_q.t_post};
        REG_CRANK:     s_d.rdata = {24'h0, s_q.t_crank};
        REG_REST:      s_d.rdata = {24'h0, s_q.t_rest};
        REG_ATTEMPTS:  s_d.rdata = {24'h0, s_q.attempts};
        REG_WARMUP:    s_d.rdata = {24'h0, s_q.t_warm};
        REG_COOL:      s_d.rdata = {24'h0, s_q.t_cool};
        REG_E2S:       s_d.rdata = {24'h0, s_q.t_e2s};
        REG_DISC_SPD:  s_d.rdata = {16'h0, s_q.disc_spd};
        REG_OIL_THR:   s_d.rdata = {16'h0, s_q.oil_thr};
        REG_STATUS:    s_d.rdata = {10'h0, s_q.lrf, s_q.ovcr, s_q.tries,
                                    4'(s_q.st), s_q.tmr};
        REG_MAP:       s_d.rdata = {8'h0, s_q.map};
        default:       s_d.rdata = 32'h0;
      endcase
    end

    // Side timers run down on each second tick.
    if (tick) begin
      if (s_q.post_tmr != 8'h00) s_d.post_tmr = s_q.post_tmr - 8'h01;
      if (s_q.warm_tmr != 8'h00) s_d.warm_tmr = s_q.warm_tmr - 8'h01;
      if (s_q.e2s_tmr  != 8'h00) s_d.e2s_tmr  = s_q.e2s_tmr  - 8'h01;
      if (s_q.fs_tmr   != 8'h00) s_d.fs_tmr   = s_q.fs_tmr   - 8'h01;
      if (s_q.tmr      != 8'h00) s_d.tmr      = s_q.tmr      - 8'h01;
    end
    // Midheat counts only while cranking; on expiry glow stops. [RQ7]
    if (tick && s_q.st == ST_CRANK && s_q.mid_tmr != 8'h00) begin
      s_d.mid_tmr = s_q.mid_tmr - 8'h01;
      if (s_q.mid_tmr == 8'h01) s_d.mid_on = 1'b0;
    end

    unique case (s_q.st)
      ST_OFF: begin
        s_d.fuel = 1'b0;
        if (k_start && !k_off) begin
          s_d.st     = ST_DELAY;
          s_d.tmr    = s_q.t_dly; // [RQ1]
          s_d.tries  = 8'h00;
          s_d.mid_tmr= s_q.t_mid;
          s_d.mid_on = (s_q.t_mid != 8'h00);
        end
      end
      ST_DELAY: begin
        if (s_q.tmr == 8'h00) begin
          s_d.st   = ST_PREHEAT;
          s_d.tmr  = s_q.t_pre;
          s_d.fuel = 1'b1; // [RQ1]
          s_d.glow = (s_q.t_pre != 8'h00);
        end
      end
      ST_PREHEAT: begin
        if (s_q.tmr == 8'h00) begin
          s_d.st     = ST_CRANK;
          s_d.tmr    = s_q.t_crank; // [RQ2]
          s_d.glow   = s_q.mid_on; // [RQ6]
          s_d.locked = 1'b0;
          s_d.tries  = s_q.tries + 8'h01;
        end
      end
      ST_CRANK: begin
        s_d.glow = s_q.mid_on; // [RQ6] [RQ23]
        if (lock_cond && !s_q.locked) begin
          s_d.locked = 1'b1;
          if (lock_left < s_q.tmr) s_d.tmr = lock_left; // [RQ16]
        end
        if (at_speed) begin
          s_d.st       = ST_RUN; // [RQ4]
          s_d.glow     = (s_q.t_post != 8'h00); // [RQ7] [RQ14]
          s_d.post_tmr = s_q.t_post;
          s_d.warm_tmr = s_q.t_warm;
          s_d.fs_tmr   = s_q.ctrl[CTRL_FALSE_EN] ? FALSE_WIN_S : 8'h00;
        end else if (s_q.tmr == 8'h00) begin
          s_d.glow = 1'b0; // [RQ7]
          if (s_q.locked) begin
            s_d.st  = ST_FAIL; // [RQ17]
            s_d.lrf = 1'b1;
            s_d.fuel= 1'b0;
          end else if (s_q.tries >= s_q.attempts) begin
            s_d.st   = ST_FAIL; // [RQ9]
            s_d.ovcr = 1'b1;
            s_d.fuel = 1'b0;
          end else begin
            s_d.st   = ST_REST; // [RQ2]
            s_d.tmr  = s_q.t_rest;
            s_d.fuel = s_q.ctrl[CTRL_FUEL_REST]; // [RQ3]
          end
        end
      end
      ST_REST: begin
        s_d.glow = 1'b0; // [RQ6]
        if (s_q.tmr == 8'h00) begin
          s_d.st     = ST_CRANK; // [RQ8]
          s_d.tmr    = s_q.t_crank;
          s_d.fuel   = 1'b1;
          s_d.glow   = s_q.mid_on;
          s_d.locked = 1'b0;
          s_d.tries  = s_q.tries + 8'h01;
        end
      end
      ST_RUN: begin
        s_d.glow = (s_q.post_tmr != 8'h00); // [RQ14] [RQ23]
        if (k_off && s_q.fs_tmr != 8'h00) begin
          s_d.st      = ST_OFF; // [RQ11]
          s_d.fuel    = 1'b0;
          s_d.glow    = 1'b0;
          s_d.e2s_tmr = s_q.t_e2s; // [RQ20]
        end else if (s_q.fs_tmr != 8'h00 && !at_speed) begin
          s_d.st     = ST_CRANK; // [RQ10]
          s_d.tmr    = s_q.t_crank;
          s_d.fs_tmr = 8'h00;
          s_d.glow   = s_q.mid_on;
          s_d.locked = 1'b0;
          s_d.tries  = 8'h01;
        end else if ((k_stop || k_off) && s_q.t_cool != 8'h00) begin
          s_d.st   = ST_COOL; // [RQ18]
          s_d.tmr  = s_q.t_cool;
          s_d.glow = 1'b0;
        end else if (k_stop || k_off) begin
          s_d.st      = ST_OFF;
          s_d.fuel    = 1'b0;
          s_d.glow    = 1'b0;
          s_d.e2s_tmr = s_q.t_e2s; // [RQ20]
        end
      end
      ST_COOL: begin
        if (s_q.tmr == 8'h00 || k_off) begin
          s_d.st      = ST_OFF; // [RQ19]
          s_d.fuel    = 1'b0;
          s_d.e2s_tmr = s_q.t_e2s; // [RQ20]
        end
      end
      ST_FAIL: begin
        s_d.fuel = 1'b0;
        s_d.glow = 1'b0;
        if (s_q.ctrl[CTRL_FAIL_CLR] || k_off) begin
          s_d.st   = ST_OFF;
          s_d.ovcr = 1'b0;
          s_d.lrf  = 1'b0;
        end
      end
      default: s_d.st = ST_OFF;
    endcase
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      s_q     <= '0; // [RQ24]
      s_q.map <= MAP_RST[23:0];
      s_q.st  <= ST_OFF;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign RDATA        = s_q.rdata;
  assign FUEL         = s_q.fuel;
  assign CRANK        = (s_q.st == ST_CRANK);
  assign GLOW         = s_q.glow; // [RQ23]
  assign DISP_BLANK   = (s_q.st == ST_CRANK) &&
                        (crank_el < BLANK_S) && !s_q.locked; // [RQ5]
  assign OVER_CRANK   = s_q.ovcr; // [RQ22]
  assign LOCKED_ROTOR = s_q.lrf;

  always_comb begin
    feat            = 8'h00;
    feat[FEAT_WARM] = (s_q.st == ST_RUN) &&
                      (s_q.warm_tmr == 8'h00); // [RQ12] [RQ13]
    feat[FEAT_E2S]  = (s_q.e2s_tmr != 8'h00); // [RQ20]
    feat[FEAT_GLOW] = s_q.glow;
    feat[FEAT_COOL] = (s_q.st == ST_COOL); // [RQ18]
    feat[FEAT_OVCR] = s_q.ovcr; // [RQ22]
    feat[FEAT_CRANK]= (s_q.st == ST_CRANK);
    feat[FEAT_RUN]  = (s_q.st == ST_RUN);
  end

  ecs_dout_map u_map (
    .MAP (s_q.map),
    .FEAT(feat),
    .DOUT(DOUT)
  );
endmodule

/* File: hw/ecs_tick.sv */
// One-second tick generator.
// Assumes MCLK at the rate given in the package.
module ecs_tick
  import ecs_pkg::*;
(
  input  wire logic MCLK,
  input  wire logic RST_B,
  input  wire logic CE,
  output logic      TICK
);
  typedef struct packed {
    logic [25:0] cnt;
    logic        tick;
  } ecs_tick_st_t;
  ecs_tick_st_t s_q, s_d;

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == 26'(TICK_CYC - 1)) begin
      s_d.cnt  = '0;
      s_d.tick = 1'b1; // [RQ24]
    end else begin
      s_d.cnt = s_q.cnt + 26'h1;
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      s_q <= '0;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  assign TICK = s_q.tick & CE;
endmodule

/* File: test/ecs_engine.sv */
// Engine model: speed, frequency and oil pressure seen by the sequencer.
// Assumes the bench raises spin to let the engine catch, after lag cycles
// of cranking, and drops spin to force a false start.
module ecs_engine (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        fuel,
  input  wire logic        crank,
  input  wire logic        spin,
  input  wire logic [7:0]  lag,
  output logic      [15:0] speed,
  output logic      [15:0] freq,
  output logic      [15:0] oil
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;
  logic       run_q;

  // The engine only keeps turning while fuel flows; a stopped engine reads
  // zero on every sensor, which also arms the locked rotor check.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 8'h00;
      run_q <= 1'b0;
    end else begin
      cnt_q <= (crank && spin && cnt_q != 8'hff) ? cnt_q + 8'h01 : 8'h00;
      run_q <= fuel && spin && (run_q || (crank && cnt_q >= lag));
    end
  end
  assign speed = run_q ? 16'h0200 : 16'h0000;
  assign freq  = run_q ? 16'h003c : 16'h0000;
  assign oil   = run_q ? 16'h0050 : 16'h0000;
endmodule

/* File: test/ecs_seq_chk.sv */
// Checker: port-level properties of the engine sequencer.
// Assumes CE stays high while cranking; shadows speed and map registers.
module ecs_chk (
  input wire logic                         MCLK,
  input wire logic                         RST_B,
  input wire logic                         CE,
  input wire logic [7:0]                   ADDR,
  input wire logic [31:0]                  WDATA,
  input wire logic                         WR,
  input wire logic [15:0]                  SPEED,
  input wire logic                         FUEL,
  input wire logic                         CRANK,
  input wire logic                         GLOW,
  input wire logic                         DISP_BLANK,
  input wire logic                         OVER_CRANK,
  input wire logic                         LOCKED_ROTOR,
  input wire logic [ecs_pkg::NUM_DOUT-1:0] DOUT
);
  import ecs_pkg::*;
  logic [15:0] disc_q;
  logic [23:0] map_q;

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      disc_q <= 16'h0000;
      map_q  <= 24'h000000;
    end else if (WR && CE) begin
      if (ADDR == REG_DISC_SPD) disc_q <= WDATA[15:0];
      if (ADDR == REG_MAP) map_q <= WDATA[23:0];
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  a_crank_fuel: assert property (CRANK |-> FUEL)
    else $error("crank output without fuel");
  a_fail_idle: assert property ((OVER_CRANK || LOCKED_ROTOR) |->
    !CRANK && !FUEL) else $error("failure with crank or fuel on");
  a_blank_crank: assert property (DISP_BLANK |-> CRANK)
    else $error("display blanked outside cranking");
  a_disc_release: assert property (CRANK && SPEED >= disc_q
    |-> ##[1:6] !CRANK) else $error("crank held above disconnect speed");
  a_glow_map: assert property ($stable(map_q) &&
    map_q[2:0] == FEAT_GLOW |-> DOUT[0] == GLOW)
    else $error("glow output not on mapped pin");
  a_map_unique: assert property ($stable(map_q) &&
    map_q[5:3] == map_q[2:0] && map_q[2:0] != FEAT_NONE |-> !DOUT[1])
    else $error("feature drives a second pin");
  a_ovcr_map: assert property ($stable(map_q) &&
    map_q[8:6] == FEAT_OVCR && map_q[5:3] != FEAT_OVCR &&
    map_q[2:0] != FEAT_OVCR |-> DOUT[2] == OVER_CRANK)
    else $error("over-crank pin differs from flag");
  a_warm_off: assert property (CRANK && map_q[11:9] == FEAT_WARM
    |-> !DOUT[3]) else $error("warm-up pin on while cranking");
endmodule

bind ecs_seq ecs_chk u_chk (
  .MCLK, .RST_B, .CE, .ADDR, .WDATA, .WR, .SPEED, .FUEL, .CRANK, .GLOW,
  .DISP_BLANK, .OVER_CRANK, .LOCKED_ROTOR, .DOUT
);

/* File: test/test_ecs_seq.sv */
// Testbench: register-driven start, run and stop scenarios.
// Assumes the engine model on the sensor inputs and a 50 MHz clock.
module test_ecs_seq;
  timeunit 1ns;
  timeprecision 1ps;
  import ecs_pkg::*;
  localparam logic [31:0] MAP_ALL = 32'h00f9435b;
  logic        MCLK, RST_B, CE, WR, RD, START_KEY, STOP_KEY, OFF_KEY, spin;
  logic [7:0]  ADDR, lag, DOUT;
  logic [31:0] WDATA, RDATA, rv;
  logic [15:0] SPEED, FREQ, OIL;
  logic        FUEL, CRANK, GLOW, DISP_BLANK, OVER_CRANK, LOCKED_ROTOR;
  int          n_mismatch, total_checks, cyc;

  ecs_seq u_dut (.MCLK(MCLK), .RST_B(RST_B), .CE(CE), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SPEED(SPEED),
    .FREQ(FREQ), .OIL(OIL), .START_KEY(START_KEY), .STOP_KEY(STOP_KEY),
    .OFF_KEY(OFF_KEY), .FUEL(FUEL), .CRANK(CRANK), .GLOW(GLOW),
    .DISP_BLANK(DISP_BLANK), .OVER_CRANK(OVER_CRANK),
    .LOCKED_ROTOR(LOCKED_ROTOR), .DOUT(DOUT));
  ecs_engine u_eng (.mclk(MCLK), .rst_b(RST_B), .fuel(FUEL), .crank(CRANK),
    .spin(spin), .lag(lag), .speed(SPEED), .freq(FREQ), .oil(OIL));

  initial begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end

  // --------------------------------------------------------------------
  // Bus, key and comparison tasks
  // --------------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask
  task automatic wait_st(input ecs_state_t s);
    int i;
    i = 0;
    rd(REG_STATUS, rv);
    while (rv[11:8] !== s && i < 40) begin
      rd(REG_STATUS, rv);
      i++;
    end
    chk("state", {28'h0, s}, {28'h0, rv[11:8]});
  endtask
  task automatic press(input int k);
    @(posedge MCLK);
    START_KEY <= (k == 0);
    STOP_KEY <= (k == 1);
    OFF_KEY <= (k == 2);
    repeat (4) @(posedge MCLK);
    START_KEY <= 1'b0;
    STOP_KEY <= 1'b0;
    OFF_KEY <= 1'b0;
  endtask
  // Timer bytes from the top: delay, preheat, midheat, postheat, crank,
  // rest, attempts, warm-up, cool-down, energize_to_stop. The tick never
  // comes in a short run, so a nonzero time holds its state still.
  task automatic boot(input logic [79:0] t, input logic [31:0] ctl);
    @(posedge MCLK);
    RST_B <= 1'b0;
    spin <= 1'b0;
    repeat (4) @(posedge MCLK);
    RST_B <= 1'b1;
    for (int i = 0; i < 10; i++) wr(8'(4 + 4 * i), {24'h0, t[79-8*i -: 8]});
    wr(REG_DISC_SPD, 32'h00000100);
    wr(REG_MAP, MAP_ALL);
    wr(REG_CTRL, ctl);
    press(0);
  endtask
  task automatic done(input string n);
    $display("test %s done, mismatches so far %0d", n, n_mismatch);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  initial begin
    {RST_B, CE, WR, RD, START_KEY, STOP_KEY, OFF_KEY, spin} = 8'b01000000;
    ADDR = 8'h00;
    WDATA = 32'h0;
    lag = 8'h00;
    n_mismatch = 0;
    total_checks = 0;
    cyc = 0;
    repeat (4) @(posedge MCLK);
    RST_B <= 1'b1;
    rd(REG_COOL, rv);
    chk("cool reset", 32'h0, rv);
    CE <= 1'b0;
    wr(REG_COOL, 32'h00000077);
    CE <= 1'b1;
    rd(REG_COOL, rv);
    chk("frozen write", 32'h0, rv);
    wr(REG_STATUS, 32'hffffffff);
    wr(8'h3c, 32'h5a5a5a5a);
    rd(REG_STATUS, rv);
    chk("status", 32'h0, rv);
    rd(8'h3c, rv);
    chk("unmapped", 32'h0, rv);
    for (int i = 0; i < 12; i++) wr(8'(4 + 4 * i), 32'(i + 1));
    for (int i = 0; i < 12; i++) begin
      rd(8'(4 + 4 * i), rv);
      chk("config", 32'(i + 1), rv);
    end
    wr(REG_CTRL, 32'h7);
    rd(REG_CTRL, rv);
    chk("ctrl", 32'h3, rv);
    done("registers");
    boot(80'h05_05_00_00_05_00_01_00_00_00, 32'h0);
    wait_st(ST_DELAY);
    chk("delay fuel", 32'h0, 32'(FUEL));
    boot(80'h00_05_00_00_05_00_01_00_00_00, 32'h0);
    wait_st(ST_PREHEAT);
    chk("preheat fuel", 32'h1, 32'(FUEL));
    chk("preheat dout", 32'h1, 32'(DOUT));
    done("start");
    for (int m = 0; m < 2; m++) begin
      boot({16'h0, (m != 0) ? 8'h05 : 8'h00, 56'h00_05_00_01_00_00_05}, 0);
      wait_st(ST_CRANK);
      chk("crank glow", 32'(m), 32'(GLOW));
      chk("blank", 32'h1, 32'(DISP_BLANK));
      chk("crank dout", (m != 0) ? 32'h41 : 32'h40, 32'(DOUT));
      lag <= (m != 0) ? 8'h1e : 8'h00;
      spin <= 1'b1;
      wait_st(ST_RUN);
      chk("run outs", 32'h1, 32'({CRANK, GLOW, FUEL}));
      chk("run dout", 32'h88, 32'(DOUT));
      press(1);
      wait_st(ST_OFF);
      chk("stop fuel", 32'h0, 32'(FUEL));
      chk("stop dout", 32'h20, 32'(DOUT));
    end
    done("crank and stop");
    boot(80'h00_00_00_05_05_00_01_05_05_00, 32'h0);
    wait_st(ST_CRANK);
    spin <= 1'b1;
    wait_st(ST_RUN);
    chk("postheat glow", 32'h1, 32'(GLOW));
    chk("warm dout", 32'h81, 32'(DOUT));
    press(1);
    wait_st(ST_COOL);
    chk("cool dout", 32'h1, 32'(DOUT[4]));
    done("cool-down");
    boot(80'h00_00_00_00_05_00_01_00_05_00, 32'h2);
    wait_st(ST_CRANK);
    spin <= 1'b1;
    wait_st(ST_RUN);
    spin <= 1'b0;
    wait_st(ST_CRANK);
    spin <= 1'b1;
    wait_st(ST_RUN);
    press(2);
    wait_st(ST_OFF);
    done("false start");
    for (int f = 0; f < 2; f++) begin
      boot(80'h00_00_05_00_00_05_03_00_00_00, 32'(f));
      wait_st(ST_REST);
      chk("rest outs", 32'(f), 32'({CRANK, GLOW, FUEL}));
    end
    done("crank rest");
    for (int a = 1; a < 4; a += 2) begin
      boot({48'h0, 8'(a), 24'h0}, 32'h0);
      wait_st(ST_FAIL);
      rd(REG_STATUS, rv);
      chk("tries", 32'(a), 32'(rv[19:12]));
      chk("status flag", 32'h1, 32'(rv[20]));
      chk("over crank", 32'h1, 32'(OVER_CRANK));
      chk("fail dout", 32'h4, 32'(DOUT));
      wr(REG_CTRL, 32'h4);
      wait_st(ST_OFF);
      chk("flag cleared", 32'h0, 32'(OVER_CRANK));
    end
    done("over-crank");
    for (int o = 0; o < 2; o++) begin
      boot(80'h00_00_00_00_05_00_01_00_00_00, 32'h0);
      wr(REG_OIL_THR, (o != 0) ? 32'h40 : 32'h0);
      wait_st(ST_CRANK);
      rd(REG_STATUS, rv);
      chk("lock timer", (o != 0) ? 32'h3 : 32'h5, 32'(rv[7:0]));
      chk("lock blank", 32'(1 - o), 32'(DISP_BLANK));
      chk("lock flag", 32'h0, 32'(LOCKED_ROTOR));
    end
    done("locked rotor");
    final_report();
  end
endmodule
